//--- rtl/mps_defs.svh
// register offsets, field positions, reset values and the interrupt vector
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH
`define MPS_REG_PC_LOW 4'h0
`define MPS_REG_STATUS 4'h1
`define MPS_REG_ACC    4'h2
`define MPS_CLS_MSB    13
`define MPS_CLS_LSB    11
`define MPS_FN_MSB     10
`define MPS_FN_LSB     7
`define MPS_DEST_BIT   6
`define MPS_INTERRUPT_RETURN_BIT   0
`define MPS_ST_C       0
`define MPS_ST_AC      1
`define MPS_ST_Z       2
`define MPS_ST_OV      3
`define MPS_PC_RESET   11'h000
`define MPS_INT_VEC    11'h004
`define MPS_ST_RESET   4'h0
`define MPS_ACC_RESET  8'h00
`define MPS_IW_RESET   14'h0000
`endif

//--- rtl/mps_pkg.sv
// types shared by the sequencer and its alu
package mps_pkg;
   typedef enum logic [2:0] {CLS_NOP, CLS_ALU, CLS_SKZ, CLS_SKNZ,
                             CLS_JUMP, CLS_CALL, CLS_RETURN, CLS_PCWR} mps_cls_type;
   typedef enum logic [3:0] {FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_DECADJ, FN_AND, FN_OR, FN_XOR,
                             FN_CPL, FN_RR, FN_RRC, FN_RL, FN_RLC, FN_INC, FN_DEC, FN_MOV} mps_fn_type;
   typedef enum logic [1:0] {PH_FETCH, PH_DEC, PH_EXA, PH_EXB} mps_phase_type;
endpackage

//--- rtl/mps_alu.sv
// 8-bit alu: arithmetic, logic, rotates, inc/dec and flag results
`timescale 1ns/10ps
module mps_alu
   import mps_pkg::*;
(
   input  wire mps_fn_type  fn_in,   // operation
   input  wire logic [7:0]  a_in,    // accumulator
   input  wire logic [7:0]  b_in,    // memory operand
   input  wire logic        c_in,    // carry flag now
   input  wire logic        ac_in,   // half carry now
   input  wire logic        z_in,    // zero flag now
   input  wire logic        ov_in,   // overflow now
   output logic [7:0]       res_out, // result
   output logic             c_out,   // carry after
   output logic             ac_out,  // half carry after
   output logic             z_out,   // zero after
   output logic             ov_out   // overflow after
);
   // one adder serves add, sub, inc and dec; carry means no borrow
   always_comb begin
      logic [7:0] x;
      logic [7:0] y;
      logic       ci;
      logic [8:0] sum;
      logic [4:0] hs;
      logic [8:0] dj;
      x = a_in;
      y = b_in;
      ci = 1'b0;
      case (fn_in)
         FN_ADC: ci = c_in;
         FN_SUB: begin y = ~b_in; ci = 1'b1; end
         FN_SBC: begin y = ~b_in; ci = c_in; end
         FN_INC: begin x = b_in; y = 8'h00; ci = 1'b1; end
         FN_DEC: begin x = b_in; y = 8'hFF; end
         default: ;
      endcase
      sum = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      hs = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      // decimal adjust corrects the accumulator after a bcd add
      dj = {1'b0, a_in};
      if (a_in[3:0] > 4'h9 || ac_in) begin
         dj = dj + 9'h006;
      end
      if (dj[7:4] > 4'h9 || c_in || dj[8]) begin
         dj = dj + 9'h060;
      end
      res_out = sum[7:0];
      c_out = c_in;
      ac_out = ac_in;
      ov_out = ov_in;
      case (fn_in)
         FN_ADD, FN_ADC, FN_SUB, FN_SBC: begin
            c_out = sum[8];
            ac_out = hs[4];
            ov_out = (x[7] == y[7]) && (sum[7] != x[7]);
         end
         FN_DECADJ: begin res_out = dj[7:0]; c_out = dj[8] | c_in; end
         FN_AND: res_out = a_in & b_in;
         FN_OR:  res_out = a_in | b_in;
         FN_XOR: res_out = a_in ^ b_in;
         FN_CPL: res_out = ~b_in;
         FN_RR:  res_out = {b_in[0], b_in[7:1]};
         FN_RRC: begin res_out = {c_in, b_in[7:1]}; c_out = b_in[0]; end
         FN_RL:  res_out = {b_in[6:0], b_in[7]};
         FN_RLC: begin res_out = {b_in[6:0], c_in}; c_out = b_in[7]; end
         FN_MOV: res_out = b_in;
         default: ;
      endcase
      // rotates and moves leave the zero flag alone
      case (fn_in)
         FN_RR, FN_RRC, FN_RL, FN_RLC, FN_MOV: z_out = z_in;
         default: z_out = (res_out == 8'h00);
      endcase
   end
endmodule

//--- rtl/mps_seq.sv
// program sequencer: phases, fetch pipeline, pc, return stack, alu control
//
// Overview of operation
// [RQ1] four phases make one instruction cycle
// [RQ2] pc advances, next word fetched in fetch_phase
// [RQ3] execute_phases decode and execute current word
// [RQ4] fetch overlaps execute: one per cycle
// [RQ5] jumps and calls take two cycles, flush
// [RQ6] taken skip replaces prefetched word by dummy
// [RQ7] sequential execution adds exactly one to pc
// [RQ8] pc is low byte plus 2/3 bits
// [RQ9] only pc_low_byte is software visible
// [RQ10] pc_low_byte write branches in page, dummy cycle
// [RQ11] jump, call, interrupt, reset load pc
// [RQ12] reset starts at address zero
// [RQ13] stack holds pc only, hidden from software
// [RQ14] call/ack push pc, returns pop it
// [RQ15] reset empties the stack
// [RQ16] full stack holds off interrupt acknowledge
// [RQ17] call on full stack drops oldest entry
// [RQ18] alu works on bytes, writes chosen destination
// [RQ19] status flags follow each alu result; code updates them for alu class only, skip results leave them
// [RQ20] alu covers arithmetic, logic, rotate, skip ops
// [RQ21] stack depth parameter, full flag from pointer
`timescale 1ns/10ps
`include "mps_defs.svh"
module mps_seq
   import mps_pkg::*;
#(
   parameter int          PC_W    = 10,          // 10 for 1K words, 11 for 2K
   parameter int          DEPTH   = 8,           // return stack levels
   parameter logic [10:0] INT_VEC = `MPS_INT_VEC // interrupt entry address
) (
   input  wire logic            CORE_CLK_IN,    // system clock
   input  wire logic            RST_IN,         // async reset, high
   input  wire logic [3:0]      REG_ADDR_IN,    // register address
   input  wire logic [7:0]      REG_WDATA_IN,   // register write data
   input  wire logic            REG_WR_IN,      // write strobe
   input  wire logic            REG_RD_IN,      // read strobe
   output logic [7:0]           REG_RDATA_OUT,  // read data, one cycle later
   output logic [PC_W-1:0]      PM_ADDR_OUT,    // program memory address
   output logic                 PM_RD_OUT,      // fetch strobe
   input  wire logic [13:0]     PM_DATA_IN,     // fetched word
   input  wire logic [7:0]      DATA_IN,        // data memory operand
   output logic [7:0]           DATA_OUT,       // alu result to memory
   output logic                 DATA_WE_OUT,    // memory write pulse
   input  wire logic            INT_REQ_IN,     // enabled interrupt request
   output logic                 INT_ACK_OUT,    // acknowledge pulse
   output logic                 INT_RETURN_OUT, // interrupt return pulse
   output logic [3:0]           PHASE_OUT,      // one-hot phase
   output logic                 STACK_FULL_OUT  // stack full level
);
   localparam int SP_W = $clog2(DEPTH + 1);

   mps_phase_type   ph_q;              // current phase
   logic [PC_W-1:0] pc_q;              // program counter
   logic [13:0]     pf_q;              // prefetched word
   logic            pf_valid_q;        // prefetch still wanted
   logic [13:0]     ir_q;              // word under execution
   logic            ir_valid_q;        // low in a dummy cycle
   logic [7:0]      acc_q;             // accumulator
   logic [3:0]      st_q;              // c, ac, z, ov
   logic [PC_W-1:0] stk_q [DEPTH];     // return stack, entry 0 newest
   logic [PC_W-1:0] push_in [DEPTH];   // value each entry takes on push
   logic [PC_W-1:0] pop_in [DEPTH];    // value each entry takes on pop
   logic [SP_W-1:0] sp_q;              // levels in use
   logic            int_pend_q;        // interrupt request flag
   logic            ack_q;             // acknowledge pulse
   logic            iret_q;            // interrupt return pulse
   logic [7:0]      data_q;            // memory write data
   logic            data_we_q;         // memory write pulse
   logic [7:0]      rdata_q;           // read data
   mps_cls_type     cls;               // instruction class
   mps_fn_type      fn;                // alu function
   logic            dest_mem;          // result to memory
   logic [PC_W-1:0] target;            // jump or call address
   logic [PC_W-1:0] ret_val;           // address pushed
   logic            exec;              // real instruction at execute edge
   logic            pcl_wr;            // software writes pc_low_byte
   logic            full;              // stack full
   logic            skip_taken;        // skip condition met
   logic            flow;              // pc leaves sequence
   logic            ack_now;           // acknowledge this edge
   logic            push;              // stack push
   logic            pop;               // stack pop
   logic [7:0]      alu_res;           // alu result
   logic            alu_c;             // alu carry
   logic            alu_ac;            // alu half carry
   logic            alu_z;             // alu zero
   logic            alu_ov;            // alu overflow

   // register address match, used by read and write
   function automatic logic reg_is(input logic [3:0] a, input logic [3:0] r);
      return a == r;
   endfunction

   // decode fields of the word under execution
   assign cls = mps_cls_type'(ir_q[`MPS_CLS_MSB:`MPS_CLS_LSB]);
   assign fn = mps_fn_type'(ir_q[`MPS_FN_MSB:`MPS_FN_LSB]);
   assign dest_mem = ir_q[`MPS_DEST_BIT];
   assign target = ir_q[PC_W-1:0];
   // execute happens on the edge that ends the last phase
   assign exec = (ph_q == PH_EXB) && ir_valid_q; // [RQ3]
   assign pcl_wr = REG_WR_IN && reg_is(REG_ADDR_IN, `MPS_REG_PC_LOW); // [RQ9]
   assign full = (sp_q == SP_W'(DEPTH)); // [RQ21]
   assign skip_taken = exec && (((cls == CLS_SKZ) && (alu_res == 8'h00)) ||
                                ((cls == CLS_SKNZ) && (alu_res != 8'h00))); // [RQ6]
   assign flow = skip_taken || (exec && ((cls == CLS_JUMP) || (cls == CLS_CALL) ||
                                         (cls == CLS_RETURN) || (cls == CLS_PCWR)));
   // acknowledge only at a clean boundary with a valid prefetch to return to
   assign ack_now = (ph_q == PH_EXB) && int_pend_q && !full && pf_valid_q &&
                    !flow && !pcl_wr; // [RQ16]
   assign push = (exec && (cls == CLS_CALL)) || ack_now; // [RQ14]
   assign pop = exec && (cls == CLS_RETURN); // [RQ14]
   // pc already runs one past the prefetched word
   assign ret_val = pc_q - PC_W'(1);

   // shared alu; operand a is the accumulator, b the memory byte
   mps_alu u_alu (
      .fn_in   (fn),
      .a_in    (acc_q),
      .b_in    (DATA_IN),
      .c_in    (st_q[`MPS_ST_C]),
      .ac_in   (st_q[`MPS_ST_AC]),
      .z_in    (st_q[`MPS_ST_Z]),
      .ov_in   (st_q[`MPS_ST_OV]),
      .res_out (alu_res),
      .c_out   (alu_c),
      .ac_out  (alu_ac),
      .z_out   (alu_z),
      .ov_out  (alu_ov)
   ); // [RQ20]

   // phase sequencer: fetch then three execute phases
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ph_q <= PH_FETCH;
      end else begin
         case (ph_q) // [RQ1]
            PH_FETCH: ph_q <= PH_DEC;
            PH_DEC:   ph_q <= PH_EXA;
            PH_EXA:   ph_q <= PH_EXB;
            default:  ph_q <= PH_FETCH;
         endcase
      end
   end

   // program counter; software write has top priority
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pc_q <= PC_W'(`MPS_PC_RESET); // [RQ12]
      end else if (pcl_wr) begin
         pc_q <= {pc_q[PC_W-1:8], REG_WDATA_IN}; // [RQ10] [RQ8]
      end else if (exec && ((cls == CLS_JUMP) || (cls == CLS_CALL))) begin
         pc_q <= target; // [RQ11]
      end else if (pop) begin
         pc_q <= stk_q[0]; // [RQ14]
      end else if (exec && (cls == CLS_PCWR)) begin
         pc_q <= {pc_q[PC_W-1:8], acc_q}; // [RQ10]
      end else if (ack_now) begin
         pc_q <= INT_VEC[PC_W-1:0]; // [RQ11]
      end else if (ph_q == PH_FETCH) begin
         pc_q <= pc_q + PC_W'(1); // [RQ2] [RQ7]
      end
   end

   // fetch pipeline: prefetch word moves to execute each cycle
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pf_q <= `MPS_IW_RESET;
         pf_valid_q <= 1'b0;
         ir_q <= `MPS_IW_RESET;
         ir_valid_q <= 1'b0;
      end else if (ph_q == PH_FETCH) begin
         pf_q <= PM_DATA_IN; // [RQ2]
         ir_q <= pf_q; // [RQ4]
         ir_valid_q <= pf_valid_q && !pcl_wr; // [RQ5] [RQ10]
         pf_valid_q <= !pcl_wr; // [RQ10]
      end else begin
         // flushed word becomes a dummy cycle
         if (pcl_wr || flow || ack_now) begin
            pf_valid_q <= 1'b0; // [RQ5] [RQ6]
         end
         // a bus write also cancels the word under execution, so a later jump cannot undo the branch
         if (pcl_wr) begin
            ir_valid_q <= 1'b0; // [RQ10]
         end
      end
   end

   // stack pointer; a push on a full stack keeps it full
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         sp_q <= '0; // [RQ15]
      end else if (push && !full) begin
         sp_q <= sp_q + SP_W'(1);
      end else if (pop && (sp_q != '0)) begin
         sp_q <= sp_q - SP_W'(1);
      end
   end

   // stack as shift register: overflow shifts the oldest out the bottom
   // no software path reaches these entries or the pointer
   genvar i;
   for (i = 0; i < DEPTH; i++) begin : g_stk
      if (i == 0) begin : g_top
         assign push_in[i] = ret_val;
      end else begin : g_mid
         assign push_in[i] = stk_q[i-1];
      end
      if (i == DEPTH - 1) begin : g_bot
         assign pop_in[i] = '0;
      end else begin : g_up
         assign pop_in[i] = stk_q[i+1];
      end
      always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
         if (RST_IN) begin
            stk_q[i] <= '0; // [RQ13]
         end else if (push) begin
            stk_q[i] <= push_in[i]; // [RQ17]
         end else if (pop) begin
            stk_q[i] <= pop_in[i];
         end
      end
   end

   // interrupt flag: a new request wins over the clear by acknowledge
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         int_pend_q <= 1'b0;
      end else begin
         int_pend_q <= INT_REQ_IN || (int_pend_q && !ack_now); // [RQ16]
      end
   end

   // registered interrupt pulses
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ack_q <= 1'b0;
         iret_q <= 1'b0;
      end else begin
         ack_q <= ack_now;
         iret_q <= pop && ir_q[`MPS_INTERRUPT_RETURN_BIT];
      end
   end

   // accumulator takes alu class results aimed at it; skips never write it
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         acc_q <= `MPS_ACC_RESET;
      end else if (exec && (cls == CLS_ALU) && !dest_mem) begin
         acc_q <= alu_res; // [RQ18]
      end
   end

   // status flags follow alu class only; skips leave them alone
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         st_q <= `MPS_ST_RESET;
      end else if (exec && (cls == CLS_ALU)) begin
         st_q[`MPS_ST_C] <= alu_c; // [RQ19]
         st_q[`MPS_ST_AC] <= alu_ac;
         st_q[`MPS_ST_Z] <= alu_z;
         st_q[`MPS_ST_OV] <= alu_ov;
      end
   end

   // memory write-back; skips write back only when aimed at memory
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         data_q <= 8'h00;
         data_we_q <= 1'b0;
      end else begin
         data_we_q <= exec && dest_mem &&
                      ((cls == CLS_ALU) || (cls == CLS_SKZ) || (cls == CLS_SKNZ)); // [RQ18]
         if (exec && dest_mem) begin
            data_q <= alu_res;
         end
      end
   end

   // register reads: data stands in the next cycle only
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rdata_q <= 8'h00;
      end else if (!REG_RD_IN) begin
         rdata_q <= 8'h00;
      end else if (reg_is(REG_ADDR_IN, `MPS_REG_PC_LOW)) begin
         rdata_q <= pc_q[7:0]; // [RQ9]
      end else if (reg_is(REG_ADDR_IN, `MPS_REG_STATUS)) begin
         rdata_q <= {4'h0, st_q};
      end else if (reg_is(REG_ADDR_IN, `MPS_REG_ACC)) begin
         rdata_q <= acc_q;
      end else begin
         // unmapped addresses, high pc bits included, read zero
         rdata_q <= 8'h00;
      end
   end

   // outputs
   assign REG_RDATA_OUT = rdata_q;
   assign PM_ADDR_OUT = pc_q;
   assign PM_RD_OUT = (ph_q == PH_FETCH);
   assign DATA_OUT = data_q;
   assign DATA_WE_OUT = data_we_q;
   assign INT_ACK_OUT = ack_q;
   assign INT_RETURN_OUT = iret_q;
   assign PHASE_OUT = 4'h1 << ph_q; // [RQ1]
   assign STACK_FULL_OUT = full;

   // checks
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RST_IN);

   phase_ring_a: assert property ( // [RQ1]
      $onehot(PHASE_OUT) && (PHASE_OUT == 4'h1) |=> PHASE_OUT == 4'h2 ##1 PHASE_OUT == 4'h4
                                                    ##1 PHASE_OUT == 4'h8 ##1 PHASE_OUT == 4'h1)
      else $error("phase ring broken");
   pc_step_a: assert property ( // [RQ7]
      (ph_q == PH_FETCH) && !pcl_wr |=> pc_q == PC_W'($past(pc_q) + PC_W'(1)))
      else $error("pc did not advance by one");
   exec_late_a: assert property ( // [RQ3]
      DATA_WE_OUT |-> PM_RD_OUT && $past(ph_q == PH_EXB))
      else $error("write-back outside execute");
   jump_flush_a: assert property ( // [RQ5]
      exec && (cls == CLS_JUMP) && !pcl_wr |=> pc_q == $past(target) ##1 !ir_valid_q)
      else $error("jump did not load and flush");
   skip_dummy_a: assert property ( // [RQ6]
      skip_taken && !pcl_wr |=> !pf_valid_q ##1 !ir_valid_q)
      else $error("skip did not insert dummy");
   pcl_branch_a: assert property ( // [RQ10]
      pcl_wr |=> pc_q[7:0] == $past(REG_WDATA_IN) &&
                 pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8]) && !pf_valid_q)
      else $error("pc low write wrong");
   call_push_a: assert property ( // [RQ14]
      exec && (cls == CLS_CALL) && !pcl_wr |=> stk_q[0] == $past(ret_val) && pc_q == $past(target))
      else $error("call push wrong");
   full_block_a: assert property ( // [RQ16]
      INT_ACK_OUT |-> $past(sp_q) != SP_W'(DEPTH) && PHASE_OUT == 4'h1)
      else $error("acknowledge on full stack");
   over_keep_a: assert property ( // [RQ17]
      push && full |=> full && stk_q[0] == $past(ret_val))
      else $error("overflow push wrong");
   flag_zero_a: assert property ( // [RQ19]
      exec && (cls == CLS_ALU) && !dest_mem && (fn inside {FN_ADD, FN_AND, FN_OR, FN_XOR}) |=>
         st_q[`MPS_ST_Z] == (acc_q == 8'h00))
      else $error("zero flag mismatch");

   call_seen_c: cover property (exec && (cls == CLS_CALL));
   skip_seen_c: cover property (skip_taken);
   ack_seen_c: cover property (INT_ACK_OUT);
   full_wait_c: cover property (int_pend_q && full ##[1:40] INT_ACK_OUT);
endmodule

//--- sim/mps_prog_mem.sv
// program memory and interrupt request model facing the sequencer
`timescale 1ns/10ps
module mps_prog_mem #(
   parameter int PC_W = 10 // program address width
) (
   input  wire logic            clk_in,   // system clock
   input  wire logic            rst_in,   // async reset, high
   input  wire logic [PC_W-1:0] addr_in,  // fetch address
   input  wire logic            rd_in,    // fetch phase strobe
   output logic [13:0]          data_out, // instruction word
   input  wire logic            raise_in, // bench asks for an interrupt
   input  wire logic            ack_in,   // acknowledge from sequencer
   output logic                 req_out,  // registered request, one cycle per raise
   input  wire logic            we_in,    // data memory write pulse
   input  wire logic [7:0]      wdata_in  // data memory write value
);
   logic [13:0]     mem [0:(1<<PC_W)-1]; // program words, loaded by the bench
   logic [PC_W-1:0] trace[$];             // fetch address log
   logic [7:0]      wr_q[$];              // memory write log
   int              ack_cnt = 0;          // acknowledges seen
   // word only valid in the fetch phase; inverted elsewhere so a late sample shows
   assign data_out = rd_in ? mem[addr_in] : ~mem[addr_in];
   // one-cycle request per raise; a held level would set the flag again after acknowledge
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         req_out <= 1'b0;
      end else begin
         req_out <= raise_in;
      end
   end
   // log every fetch and every memory write
   always @(posedge clk_in) begin
      if (!rst_in && rd_in) begin
         trace.push_back(addr_in);
      end
      if (!rst_in && we_in) begin
         wr_q.push_back(wdata_in);
      end
      if (!rst_in && ack_in) begin
         ack_cnt++;
      end
   end
endmodule

//--- sim/testbench.sv
// self-checking bench for the program sequencer
`timescale 1ns/10ps
`include "mps_defs.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module testbench
   import mps_pkg::*;
;
   logic        clk = 1'b0;        // system clock
   logic        rst = 1'b1;        // reset, high
   logic [3:0]  reg_addr = 4'h0;   // register address
   logic [7:0]  reg_wdata = 8'h00; // register write data
   logic        reg_wr = 1'b0;     // write strobe
   logic        reg_rd = 1'b0;     // read strobe
   logic [7:0]  data_in = 8'h05;   // data memory operand, fixed
   logic        raise = 1'b0;      // interrupt request to the model
   logic [7:0]  rdata;             // read data
   logic [9:0]  pm_addr;           // fetch address
   logic        pm_rd;             // fetch strobe
   logic [13:0] pm_data;           // fetched word
   logic [7:0]  dout;              // memory write value
   logic        we;                // memory write pulse
   logic        int_req;           // one-cycle request from the model
   logic        int_ack;           // acknowledge pulse
   logic        int_ret;           // interrupt return pulse
   logic [3:0]  phase;             // one-hot phase
   logic        full;              // stack full
   int          err_total = 0;     // mismatches
   int          checks = 0;        // comparisons
   int          cyc = 0;           // timeout counter
   int          n;                 // bounded wait counter
   logic        hit;               // event seen
   logic [7:0]  rv;                // read value
   logic [9:0]  exp_tr [15] = '{10'h000, 10'h001, 10'h002, 10'h110, 10'h111, 10'h120, 10'h121, 10'h111,
                                 10'h112, 10'h105, 10'h106, 10'h107, 10'h108, 10'h109, 10'h108};

   always #20 clk = ~clk;

   // small stack so that the full case is reached quickly
   mps_seq #(.PC_W(10), .DEPTH(2)) i_dut (
      .CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata),
      .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .PM_ADDR_OUT(pm_addr),
      .PM_RD_OUT(pm_rd), .PM_DATA_IN(pm_data), .DATA_IN(data_in), .DATA_OUT(dout),
      .DATA_WE_OUT(we), .INT_REQ_IN(int_req), .INT_ACK_OUT(int_ack), .INT_RETURN_OUT(int_ret),
      .PHASE_OUT(phase), .STACK_FULL_OUT(full));

   mps_prog_mem #(.PC_W(10)) i_pm (
      .clk_in(clk), .rst_in(rst), .addr_in(pm_addr), .rd_in(pm_rd), .data_out(pm_data),
      .raise_in(raise), .ack_in(int_ack), .req_out(int_req), .we_in(we), .wdata_in(dout));

   // builds one instruction word
   function automatic logic [13:0] w(input mps_cls_type c, input mps_fn_type f, input logic d,
                                     input logic [9:0] t);
      return {c, f, d, 6'h00} | {4'h0, t};
   endfunction

   task reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task pulse_irq;
      @(posedge clk);
      raise <= 1'b1;
      @(posedge clk);
      raise <= 1'b0;
   endtask

   // bounded wait for acknowledge (sel 0) or interrupt return (sel 1)
   task wait_ev(input int sel, input int lim, output logic h);
      h = 1'b0;
      n = 0;
      while (!h && n < lim) begin
         @(negedge clk);
         n++;
         if ((sel == 0 ? int_ack : int_ret) === 1'b1) h = 1'b1;
      end
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // hang guard, far above the roughly 150 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict();
      end
   end

   initial begin
      for (int i = 0; i < 1024; i++) i_pm.mem[i] = 14'h0000;
      i_pm.mem[10'h000] = w(CLS_ALU, FN_ADD, 1'b0, 10'h000);    // acc = 0 + 5
      i_pm.mem[10'h001] = w(CLS_JUMP, FN_ADD, 1'b0, 10'h110);
      i_pm.mem[10'h002] = w(CLS_ALU, FN_DEC, 1'b1, 10'h000);    // flushed, must not write
      i_pm.mem[10'h110] = w(CLS_CALL, FN_ADD, 1'b0, 10'h120);
      i_pm.mem[10'h111] = w(CLS_PCWR, FN_ADD, 1'b0, 10'h000);   // page stays 1
      i_pm.mem[10'h120] = w(CLS_RETURN, FN_ADD, 1'b0, 10'h000);
      i_pm.mem[10'h105] = w(CLS_SKZ, FN_XOR, 1'b0, 10'h000);    // 5 xor 5 is zero: skip
      i_pm.mem[10'h106] = w(CLS_ALU, FN_DEC, 1'b1, 10'h000);    // skipped
      i_pm.mem[10'h107] = w(CLS_ALU, FN_INC, 1'b1, 10'h000);    // writes 6
      i_pm.mem[10'h108] = w(CLS_JUMP, FN_ADD, 1'b0, 10'h108);
      i_pm.mem[10'h004] = w(CLS_CALL, FN_ADD, 1'b0, 10'h030);
      i_pm.mem[10'h030] = w(CLS_JUMP, FN_ADD, 1'b0, 10'h030);
      i_pm.mem[10'h031] = w(CLS_RETURN, FN_ADD, 1'b0, 10'h001); // interrupt return
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 1; i <= 8; i++) begin
         @(posedge clk);
         @(negedge clk);
         `CHK("phase", 4'h1 << (i % 4), phase)
      end
      reg_read(4'hF, rv);
      `CHK("unmapped read", 8'h00, rv)
      reg_write(`MPS_REG_STATUS, 8'hFF);
      reg_read(`MPS_REG_STATUS, rv);
      `CHK("status", 8'h00, rv)
      n = 0;
      while (i_pm.trace.size() < 15 && n < 300) begin
         @(negedge clk);
         n++;
      end
      for (int i = 0; i < 15; i++) begin
         `CHK("fetch address", exp_tr[i], i_pm.trace[i])
      end
      `CHK("write count", 1, i_pm.wr_q.size())
      `CHK("write value", 8'h06, i_pm.wr_q[0])
      reg_read(`MPS_REG_ACC, rv);
      `CHK("acc", 8'h05, rv)
      pulse_irq();
      wait_ev(0, 40, hit);
      `CHK("first ack", 1'b1, hit)
      repeat (16) @(negedge clk);
      `CHK("stack full", 1'b1, full)
      pulse_irq();
      wait_ev(0, 40, hit);
      `CHK("ack held off", 1'b0, hit)
      reg_write(`MPS_REG_PC_LOW, 8'h31);
      wait_ev(1, 40, hit);
      `CHK("interrupt return", 1'b1, hit)
      wait_ev(0, 40, hit);
      `CHK("late ack", 1'b1, hit)
      @(negedge clk);
      `CHK("ack count", 2, i_pm.ack_cnt)
      print_verdict();
   end
endmodule
